// file: rtl/xfer_wait_pkg.sv
// constants shared by the transfer and wait execution block
// ==========================================================
// Function
// - stack-to-index opcode loads index pair with stack pointer plus one, two cycles, flags kept
// - index-to-stack opcode loads stack pointer with index pair minus one, two cycles
// - wait opcode decoded from one inherent byte, enables interrupts, one cycle listed
// - wait clears interrupt mask, keeps other flags, stops core clocking until interrupt
`default_nettype none
package xfer_wait_pkg;
  localparam logic [7:0] OP_STACK_TO_INDEX = 8'h95;
  localparam logic [7:0] OP_INDEX_TO_STACK = 8'h94;
  localparam logic [7:0] OP_INDEX_LOW_TO_ACC = 8'h9f;
  localparam logic [7:0] OP_WAIT = 8'h8f;
  localparam logic [7:0] OP_RESET = 8'h00;
  localparam logic [15:0] PAIR_STEP = 16'h0001;
  localparam int MASK_BIT = 3;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [15:0] PAIR_RESET = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h68;
  typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_WAIT} exec_state_t;
endpackage : xfer_wait_pkg
`default_nettype wire

// file: rtl/cpu_regs.sv
// register file holding stack pointer, index pair, accumulator and condition flags
`timescale 1ns/10ps
`default_nettype none
module cpu_regs
  import xfer_wait_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sp_we,
  input wire logic [15:0] sp_wdata,
  input wire logic pair_we,
  input wire logic [15:0] pair_wdata,
  input wire logic acc_we,
  input wire logic [7:0] acc_wdata,
  input wire logic flags_we,
  input wire logic [7:0] flags_wdata,
  output logic [15:0] sp_q,
  output logic [15:0] pair_q,
  output logic [7:0] acc_q,
  output logic [7:0] flags_q
);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sp_q <= SP_RESET;
      pair_q <= PAIR_RESET;
      acc_q <= ACC_RESET;
      flags_q <= FLAGS_RESET;
    end else begin
      if (sp_we) sp_q <= sp_wdata;
      if (pair_we) pair_q <= pair_wdata;
      if (acc_we) acc_q <= acc_wdata;
      if (flags_we) flags_q <= flags_wdata;
    end
  end
endmodule : cpu_regs
`default_nettype wire

// file: rtl/cpu_transfer_and_wait_ops.sv
// execution of the stack/index/accumulator transfers and the wait instruction
`timescale 1ns/10ps
`default_nettype none
module cpu_transfer_and_wait_ops
  import xfer_wait_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic irq_pin,
  output logic op_ready,
  output logic op_done,
  output logic core_clk_en,
  output logic [15:0] stack_pointer,
  output logic [15:0] index_pair,
  output logic [7:0] accumulator,
  output logic [7:0] condition_flags
);
  // ==========================================================
  // interrupt request synchroniser
  // the pin is asynchronous; only the second flop feeds the wake decode
  logic irq_meta_reg;
  logic irq_sync_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
    end else begin
      irq_meta_reg <= irq_pin;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  // ==========================================================
  // decode
  exec_state_t state_reg;
  exec_state_t state_next;
  logic [7:0] op_reg;
  wire idle = (state_reg == ST_IDLE);
  wire take = idle && op_valid;
  wire is_s2i = (opcode == OP_STACK_TO_INDEX);
  wire is_i2s = (opcode == OP_INDEX_TO_STACK);
  wire is_x2a = (opcode == OP_INDEX_LOW_TO_ACC);
  wire is_wait = (opcode == OP_WAIT);
  wire two_cycle = is_s2i || is_i2s;
  wire second = (state_reg == ST_SECOND);
  wire wake = (state_reg == ST_WAIT) && irq_sync_reg;
  // anything not decoded above retires in one cycle with no register write
  wire one_cycle = !(two_cycle || is_wait);

  logic [15:0] sp_q;
  logic [15:0] pair_q;
  logic [7:0] acc_q;
  logic [7:0] flags_q;

  // writes land in the second cycle for the two-cycle moves
  wire pair_we = second && (op_reg == OP_STACK_TO_INDEX);
  wire [15:0] pair_wdata = sp_q + PAIR_STEP;
  wire sp_we = second && (op_reg == OP_INDEX_TO_STACK);
  wire [15:0] sp_wdata = pair_q - PAIR_STEP;
  wire acc_we = take && is_x2a;
  wire [7:0] acc_wdata = pair_q[7:0];
  // only the mask bit moves; the rest of the flags are written back as they are
  wire flags_we = take && is_wait;
  wire [7:0] flags_wdata = flags_q & ~(8'h01 << MASK_BIT);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take && two_cycle) state_next = ST_SECOND;
        else if (take && is_wait) state_next = ST_WAIT;
      end
      ST_SECOND: state_next = ST_IDLE;
      ST_WAIT: begin
        if (irq_sync_reg) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_RESET;
    end else begin
      state_reg <= state_next;
      if (take) op_reg <= opcode;
    end
  end

  cpu_regs u_regs (
    .clk(clk),
    .rst_b(rst_b),
    .sp_we(sp_we),
    .sp_wdata(sp_wdata),
    .pair_we(pair_we),
    .pair_wdata(pair_wdata),
    .acc_we(acc_we),
    .acc_wdata(acc_wdata),
    .flags_we(flags_we),
    .flags_wdata(flags_wdata),
    .sp_q(sp_q),
    .pair_q(pair_q),
    .acc_q(acc_q),
    .flags_q(flags_q)
  );

  // ==========================================================
  // next values of the handshake and clock-gate outputs
  // ready and clock enable look at the next state, so they change together with the state register
  wire done_next = (take && one_cycle) || second || wake;
  wire ready_next = (state_next == ST_IDLE);
  wire clk_en_next = (state_next != ST_WAIT);

  // ==========================================================
  // registered outputs; the register copies trail the register file by one cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      op_ready <= 1'b0;
      op_done <= 1'b0;
      core_clk_en <= 1'b1;
      stack_pointer <= SP_RESET;
      index_pair <= PAIR_RESET;
      accumulator <= ACC_RESET;
      condition_flags <= FLAGS_RESET;
    end else begin
      op_ready <= ready_next;
      // done pulses at the end of each instruction; for wait it marks the wake-up
      op_done <= done_next;
      core_clk_en <= clk_en_next;
      stack_pointer <= sp_q;
      index_pair <= pair_q;
      accumulator <= acc_q;
      condition_flags <= flags_q;
    end
  end

  // ==========================================================
  // checks
  sequence s_take_s2i;
    take && is_s2i;
  endsequence
  sequence s_take_i2s;
    take && is_i2s;
  endsequence
  sequence s_take_wait;
    take && is_wait;
  endsequence
  sequence s_take_x2a;
    take && is_x2a;
  endsequence
  sequence s_wake;
    wake;
  endsequence

  a_s2i_value: assert property (@(posedge clk) disable iff (!rst_b)
    s_take_s2i |-> ##2 (pair_q == $past(sp_q, 2) + PAIR_STEP))
    else $error("index pair not stack pointer plus one");
  a_s2i_flags: assert property (@(posedge clk) disable iff (!rst_b)
    s_take_s2i |-> ##2 $stable(flags_q))
    else $error("flags changed by stack-to-index move");
  a_i2s_value: assert property (@(posedge clk) disable iff (!rst_b)
    s_take_i2s |-> ##1 second ##1 (sp_q == $past(pair_q, 2) - PAIR_STEP))
    else $error("stack pointer not index pair minus one");
  a_i2s_busy: assert property (@(posedge clk) disable iff (!rst_b)
    s_take_i2s |=> !idle ##1 idle)
    else $error("index-to-stack move not two cycles");
  a_wait_enter: assert property (@(posedge clk) disable iff (!rst_b)
    take && is_wait |=> state_reg == ST_WAIT)
    else $error("wait opcode not decoded");
  a_wait_mask: assert property (@(posedge clk) disable iff (!rst_b)
    take && is_wait |=> !flags_q[MASK_BIT]
      && (flags_q | (8'h01 << MASK_BIT)) == ($past(flags_q) | (8'h01 << MASK_BIT)))
    else $error("wait did not clear only the mask bit");
  a_wait_clock: assert property (@(posedge clk) disable iff (!rst_b)
    take && is_wait |=> !core_clk_en)
    else $error("core clock not stopped in wait");
  a_x2a_value: assert property (@(posedge clk) disable iff (!rst_b)
    take && is_x2a |=> acc_q == $past(pair_q[7:0]) && $stable(flags_q))
    else $error("accumulator not loaded from low index");
  a_x2a_done: assert property (@(posedge clk) disable iff (!rst_b)
    s_take_x2a |=> op_done && idle)
    else $error("accumulator move not done in one cycle");
  a_flags_kept: assert property (@(posedge clk) disable iff (!rst_b)
    !(take && is_wait) |=> $stable(flags_q))
    else $error("flags changed outside wait");

  // ==========================================================
  // checks: two-cycle moves
  a_s2i_done: assert property (@(posedge clk) disable iff (!rst_b)
    s_take_s2i |=> !op_done ##1 op_done)
    else $error("stack-to-index move not done in two cycles");
  a_s2i_busy: assert property (@(posedge clk) disable iff (!rst_b)
    s_take_s2i |=> !op_ready ##1 op_ready)
    else $error("stack-to-index move did not hold off the next byte");
  a_i2s_done: assert property (@(posedge clk) disable iff (!rst_b)
    s_take_i2s |=> !op_done ##1 op_done)
    else $error("index-to-stack move not done in two cycles");
  a_i2s_flags: assert property (@(posedge clk) disable iff (!rst_b)
    s_take_i2s |-> ##2 (flags_q == $past(flags_q, 2)))
    else $error("flags changed by index-to-stack move");

  // ==========================================================
  // checks: wait and wake-up, then single-cycle completion
  // a wake costs the two synchroniser stages on top of the pin edge
  a_wait_ready: assert property (@(posedge clk) disable iff (!rst_b)
    s_take_wait |=> !op_ready && !op_done)
    else $error("wait accepted another byte or finished at once");
  a_wait_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_WAIT) && !irq_sync_reg |=> (state_reg == ST_WAIT) && !op_done)
    else $error("wait left without an interrupt");
  a_wait_gated: assert property (@(posedge clk) disable iff (!rst_b)
    (state_reg == ST_WAIT) |-> !core_clk_en)
    else $error("core clock running while waiting");
  a_wake_done: assert property (@(posedge clk) disable iff (!rst_b)
    s_wake |=> op_done && core_clk_en && idle)
    else $error("wake-up did not restart the core");
  a_other_done: assert property (@(posedge clk) disable iff (!rst_b)
    take && one_cycle |=> op_done && idle)
    else $error("single-cycle opcode not done in one cycle");
endmodule : cpu_transfer_and_wait_ops
`default_nettype wire

// file: verif/fetch_model.sv
// instruction fetch model offering one opcode byte at a time
`timescale 1ns/10ps
`default_nettype none
module fetch_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic op_ready,
  output logic op_valid,
  output logic [7:0] opcode
);
  logic took;
  initial begin
    op_valid = 1'b0;
    opcode = 8'h00;
    took = 1'b0;
  end
  // ==========================================================
  // handshake
  always @(posedge clk) begin
    took <= op_valid & op_ready & rst_b;
  end
  // a taken byte is replaced by its inverse so stale values never look valid
  always @(negedge clk) begin
    if (took) begin
      op_valid <= 1'b0;
      opcode <= ~opcode;
    end
  end
  // single byte per instruction, no operand bytes follow
  task automatic offer(input logic [7:0] op);
    op_valid <= 1'b1;
    opcode <= op;
  endtask : offer
endmodule : fetch_model
`default_nettype wire

// file: verif/cpu_transfer_and_wait_ops_tb.sv
// self-checking bench for the transfer and wait execution block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module cpu_transfer_and_wait_ops_tb
  import xfer_wait_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b;
  logic irq_pin;
  logic op_valid, op_ready, op_done, core_clk_en;
  logic [7:0] opcode, accumulator, condition_flags, f;
  logic [15:0] stack_pointer, index_pair, e;
  int errors = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  fetch_model fm (.clk(clk), .rst_b(rst_b), .op_ready(op_ready), .op_valid(op_valid),
    .opcode(opcode));
  cpu_transfer_and_wait_ops dut (.clk(clk), .rst_b(rst_b), .op_valid(op_valid),
    .opcode(opcode), .irq_pin(irq_pin), .op_ready(op_ready), .op_done(op_done),
    .core_clk_en(core_clk_en), .stack_pointer(stack_pointer), .index_pair(index_pair),
    .accumulator(accumulator), .condition_flags(condition_flags));
  // ==========================================================
  // scenarios
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (10) @(negedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `CHK(stack_pointer, SP_RESET)
    `CHK(index_pair, PAIR_RESET)
    `CHK(condition_flags, FLAGS_RESET)
    `CHK(core_clk_en, 1'b1)
    `CHK(accumulator, ACC_RESET)
    `CHK(op_ready, 1'b1)
    `CHK(op_done, 1'b0)
  endtask : do_reset
  task automatic run(input logic [7:0] op, input int cyc);
    int n;
    n = 1;
    f = condition_flags;
    fm.offer(op);
    @(negedge clk);
    `CHK(op_ready, (cyc == 1))
    while (op_done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    `CHK(n, cyc)
    `CHK(op_ready, 1'b1)
    @(negedge clk);
    `CHK(condition_flags, f)
  endtask : run
  task automatic t_wait();
    int n;
    n = 0;
    f = condition_flags;
    fm.offer(OP_WAIT);
    repeat (3) @(negedge clk);
    `CHK(core_clk_en, 1'b0)
    `CHK(condition_flags, f & ~(8'h01 << MASK_BIT))
    `CHK(op_done, 1'b0)
    `CHK(op_ready, 1'b0)
    irq_pin <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (op_done !== 1'b1 && n < 10);
    `CHK(n <= 4, 1'b1)
    `CHK(core_clk_en, 1'b1)
    irq_pin <= 1'b0;
    @(negedge clk);
  endtask : t_wait
  task automatic complete_run();
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    #200000;
    errors++;
    complete_run();
  end
  initial begin
    irq_pin = 1'b0;
    do_reset();
    run(OP_INDEX_TO_STACK, 2);
    `CHK(stack_pointer, PAIR_RESET - PAIR_STEP)
    run(OP_STACK_TO_INDEX, 2);
    `CHK(index_pair, PAIR_RESET)
    do_reset();
    e = SP_RESET + PAIR_STEP;
    run(OP_STACK_TO_INDEX, 2);
    `CHK(index_pair, e)
    run(OP_INDEX_LOW_TO_ACC, 1);
    `CHK(accumulator, e[7:0])
    run(8'h9d, 1);
    `CHK(stack_pointer, SP_RESET)
    `CHK(index_pair, e)
    t_wait();
    complete_run();
  end
endmodule : cpu_transfer_and_wait_ops_tb
`default_nettype wire
